// file: rtl/sys_reset_pkg.sv
`default_nettype none
package sys_reset_pkg;
	// Clock rates
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned LPOSC_HZ      = 20_000_000;
	localparam int unsigned LPOSC_DIV_HZ  = 2_500_000;
	localparam int unsigned LFOSC_HZ      = 16_400;

	// Reset release synchroniser: least time, rounded up
	localparam int unsigned RELEASE_NS     = 200;
	localparam int unsigned RELEASE_CYCLES =
		(RELEASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [1:0]  RELEASE_LAST   = 2'(RELEASE_CYCLES - 1);

	// Register byte offsets
	localparam int unsigned ADR_W         = 8;
	localparam logic [7:0]  OFS_SRC_EN    = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_LOCK      = 8'h08;
	localparam logic [7:0]  OFS_APB_GATE  = 8'h0C;
	localparam logic [7:0]  OFS_CLK_CTRL  = 8'h10;
	localparam logic [7:0]  OFS_MOD_RST   = 8'h14;
	localparam logic [7:0]  OFS_SW_RESET  = 8'h18;

	// Reset sources (power-on is the i_rst input itself)
	localparam int unsigned N_SRC         = 4;
	localparam int unsigned SRC_VBAT      = 0;
	localparam int unsigned SRC_PIN       = 1;
	localparam int unsigned SRC_WDT       = 2;
	localparam int unsigned SRC_SW        = 3;
	localparam logic [3:0]  SRC_EN_RST    = 4'hF;
	localparam int unsigned STAT_POR      = 4;
	localparam logic [4:0]  STATUS_POR_RST = 5'h10;

	// Lock register
	localparam int unsigned LOCK_CLKRST   = 0;

	// Modules with optional per-module reset
	localparam int unsigned N_MOD         = 5;
	localparam int unsigned MOD_CPUMP     = 0;
	localparam int unsigned MOD_SERIAL0   = 1;
	localparam int unsigned MOD_DISPLAY   = 2;
	localparam int unsigned MOD_CAPTURE   = 3;
	localparam int unsigned MOD_RTC       = 4;
	localparam logic [4:0]  MOD_RST_RST   = 5'h00;

	// Peripheral-bus clock gates; watchdog and DMA crossbar stay on
	localparam int unsigned N_APB         = 16;
	localparam int unsigned APB_WDT       = 0;
	localparam int unsigned APB_DMA_XBAR  = 1;
	localparam logic [15:0] APB_GATE_RST  = 16'h0003;

	// Clock control fields
	localparam int unsigned CC_SYSCLK_LO  = 0;
	localparam int unsigned CC_WDT_EN     = 2;
	localparam int unsigned CC_WDT_CLK    = 3;
	localparam int unsigned CC_PULLUP     = 4;
	localparam logic [4:0]  CLK_CTRL_RST  = 5'h14;

	localparam logic [31:0] BOOT_ADDR     = 32'h0000_0000;

	typedef enum logic [1:0] {
		SYSCLK_LPOSC     = 2'h0,
		SYSCLK_LPOSC_DIV = 2'h1,
		SYSCLK_EXT       = 2'h2,
		SYSCLK_RSVD      = 2'h3
	} sysclk_sel_t;

	typedef enum logic {
		WDTCLK_LFOSC = 1'b0,
		WDTCLK_SYS   = 1'b1
	} wdt_clk_sel_t;

	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_HOLD  = 4'h2,
		ST_SYNC  = 4'h4,
		ST_START = 4'h8
	} rst_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic flash;
		logic ram;
	} ahb_clk_t;

	typedef struct packed {
		logic latch_one;
		logic open_drain;
		logic pullup_en;
	} port_ctrl_t;
endpackage
`default_nettype wire

// file: rtl/system_reset_state_control.sv
// Functional notes
// - Core halts on reset entry and stays halted until reset exits.
// - Registers load defaults; power-on-only bits survive other resets.
// - During reset port latches read one and outputs are open-drain.
// - Weak pull-ups enabled during reset and remain enabled afterwards.
// - Reset entry disables all interrupts and all timers.
// - Reset turns on high-speed bus clocks to flash and RAM.
// - Reset gates off peripheral clocks except watchdog and DMA crossbar.
// - No reset alters RAM contents.
// - Supply-monitor or power-on reset drives reset pin low until exit.
// - Leaving reset clears the program counter.
// - After reset system clock selects the low-power oscillator.
// - After reset watchdog enabled, clocked by low-frequency oscillator.
// - First fetch after reset comes from address zero.
// - Setting the lock bit blocks writes to reset-source registers.
// - Reset sources may optionally reset five individual modules.
// - Low-power oscillator gives 20 MHz, plus 2.5 MHz divided choice.
// - Watchdog low-frequency oscillator runs at nominal 16.4 kHz.
`default_nettype none
module system_reset_state_control (
	// Clock and power-on reset
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_rst,
	// Wishbone slave
	input  wire sys_reset_pkg::wb_req_t      i_wb,
	output logic                             o_wb_ack,
	output logic [31:0]                      o_wb_dat,
	// Reset sources
	input  wire logic                        i_vbat_low,
	input  wire logic                        i_wdt_expired,
	// External reset pin, open-drain
	input  wire logic                        i_rst_pin,
	output logic                             o_rst_pin,
	output logic                             o_rst_pin_oe,
	// Core control
	output logic                             o_core_halt,
	output logic                             o_pc_clear,
	output logic [31:0]                      o_fetch_addr,
	// Reset fan-out
	output logic                             o_sys_reset,
	output logic [sys_reset_pkg::N_MOD-1:0]  o_mod_reset,
	output logic                             o_ram_write_block,
	output logic                             o_irq_disable,
	output logic                             o_timer_disable,
	// Ports
	output sys_reset_pkg::port_ctrl_t        o_port,
	// Clocks
	output sys_reset_pkg::ahb_clk_t          o_ahb_clk_en,
	output logic [sys_reset_pkg::N_APB-1:0]  o_apb_clk_en,
	output sys_reset_pkg::sysclk_sel_t       o_sysclk_sel,
	output logic                             o_wdt_en,
	output sys_reset_pkg::wdt_clk_sel_t      o_wdt_clk_sel
);

	sys_reset_pkg::rst_state_t state_reg;
	sys_reset_pkg::rst_state_t state_next;
	logic [1:0]  sync_cnt_reg;
	logic [1:0]  sync_cnt_next;
	logic        pin_drive_reg;
	logic        pin_drive_next;

	logic [3:0]  src_en_reg;
	logic [3:0]  src_en_next;
	logic [4:0]  status_reg;
	logic [4:0]  status_next;
	logic        lock_reg;
	logic        lock_next;
	logic [15:0] apb_gate_reg;
	logic [15:0] apb_gate_next;
	logic [4:0]  clk_ctrl_reg;
	logic [4:0]  clk_ctrl_next;
	logic [4:0]  mod_rst_reg;
	logic [4:0]  mod_rst_next;
	logic        sw_req_reg;
	logic        sw_req_next;
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;

	logic [3:0]  src_raw;
	logic [3:0]  src_hit;
	logic        in_reset;
	logic        wr_go;

	// Byte-lane merge of a write into a register of up to 32 bits
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[b*8 +: 8] = new_val[b*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic wr_hit(
		input sys_reset_pkg::wb_req_t req,
		input logic [7:0]             ofs
	);
		return req.we && (req.adr == ofs);
	endfunction

	// Own pin drive must not feed back as a pin reset
	always_comb
	begin
		src_raw = '0;
		src_raw[sys_reset_pkg::SRC_VBAT] = i_vbat_low;
		src_raw[sys_reset_pkg::SRC_PIN]  = ~i_rst_pin & ~pin_drive_reg;
		src_raw[sys_reset_pkg::SRC_WDT]  = i_wdt_expired;
		src_raw[sys_reset_pkg::SRC_SW]   = sw_req_reg;
		src_hit = src_raw & src_en_reg;
	end

	assign in_reset = (state_reg == sys_reset_pkg::ST_HOLD) ||
		(state_reg == sys_reset_pkg::ST_SYNC);
	assign wr_go = i_wb.cyc && i_wb.stb && !ack_reg && !in_reset;

	// Reset state sequencer
	always_comb
	begin
		state_next     = state_reg;
		sync_cnt_next  = sync_cnt_reg;
		pin_drive_next = pin_drive_reg;
		unique case (state_reg)
			sys_reset_pkg::ST_RUN:
			begin
				if (|src_hit)
				begin
					state_next     = sys_reset_pkg::ST_HOLD;
					pin_drive_next = src_hit[sys_reset_pkg::SRC_VBAT];
				end
			end
			sys_reset_pkg::ST_HOLD:
			begin
				if (src_hit[sys_reset_pkg::SRC_VBAT])
					pin_drive_next = 1'b1;
				if (!(|src_hit))
				begin
					state_next    = sys_reset_pkg::ST_SYNC;
					sync_cnt_next = '0;
				end
			end
			sys_reset_pkg::ST_SYNC:
			begin
				// A source returning during release restarts the hold
				if (|src_hit)
					state_next = sys_reset_pkg::ST_HOLD;
				else if (sync_cnt_reg == sys_reset_pkg::RELEASE_LAST)
					state_next = sys_reset_pkg::ST_START;
				else
					sync_cnt_next = sync_cnt_reg + 2'h1;
			end
			sys_reset_pkg::ST_START:
			begin
				state_next     = sys_reset_pkg::ST_RUN;
				pin_drive_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			state_reg     <= sys_reset_pkg::ST_HOLD;
			sync_cnt_reg  <= '0;
			pin_drive_reg <= 1'b1;
		end
		else
		begin
			state_reg     <= state_next;
			sync_cnt_reg  <= sync_cnt_next;
			pin_drive_reg <= pin_drive_next;
		end
	end

	// Register file and bus answer
	always_comb
	begin
		src_en_next   = src_en_reg;
		status_next   = status_reg;
		lock_next     = lock_reg;
		apb_gate_next = apb_gate_reg;
		clk_ctrl_next = clk_ctrl_reg;
		mod_rst_next  = mod_rst_reg;
		sw_req_next   = 1'b0;
		ack_next      = i_wb.cyc && i_wb.stb && !ack_reg;
		rdat_next     = '0;
		if (wr_go)
		begin
			if (wr_hit(i_wb, sys_reset_pkg::OFS_SRC_EN) && !lock_reg)
				src_en_next = 4'(lane_merge(32'(src_en_reg), i_wb.dat,
					i_wb.sel));
			if (wr_hit(i_wb, sys_reset_pkg::OFS_MOD_RST) && !lock_reg)
				mod_rst_next = 5'(lane_merge(32'(mod_rst_reg), i_wb.dat,
					i_wb.sel));
			// Sticky until reset, so firmware cannot undo its own lock
			if (wr_hit(i_wb, sys_reset_pkg::OFS_LOCK) && i_wb.sel[0])
				lock_next = lock_reg
					| i_wb.dat[sys_reset_pkg::LOCK_CLKRST];
			if (wr_hit(i_wb, sys_reset_pkg::OFS_APB_GATE))
				apb_gate_next = 16'(lane_merge(32'(apb_gate_reg), i_wb.dat,
					i_wb.sel));
			if (wr_hit(i_wb, sys_reset_pkg::OFS_CLK_CTRL))
				clk_ctrl_next = 5'(lane_merge(32'(clk_ctrl_reg), i_wb.dat,
					i_wb.sel));
			if (wr_hit(i_wb, sys_reset_pkg::OFS_STATUS) && i_wb.sel[0])
				status_next = status_reg & ~i_wb.dat[4:0];
			if (wr_hit(i_wb, sys_reset_pkg::OFS_SW_RESET) && i_wb.sel[0]
				&& !lock_reg)
				sw_req_next = i_wb.dat[0];
		end
		// Cause capture after the clear so a new cause is never lost
		if (state_reg == sys_reset_pkg::ST_RUN)
			status_next[3:0] = status_next[3:0] | src_hit;
		if (i_wb.cyc && i_wb.stb && !ack_reg && !i_wb.we)
		begin
			unique case (i_wb.adr)
				sys_reset_pkg::OFS_SRC_EN:   rdat_next = 32'(src_en_reg);
				sys_reset_pkg::OFS_STATUS:   rdat_next = 32'(status_reg);
				sys_reset_pkg::OFS_LOCK:     rdat_next = 32'(lock_reg);
				sys_reset_pkg::OFS_APB_GATE: rdat_next = 32'(apb_gate_reg);
				sys_reset_pkg::OFS_CLK_CTRL: rdat_next = 32'(clk_ctrl_reg);
				sys_reset_pkg::OFS_MOD_RST:  rdat_next = 32'(mod_rst_reg);
				default:                     rdat_next = '0;
			endcase
		end
		// Ordinary bits held at defaults for the whole reset state
		if (in_reset)
		begin
			src_en_next   = sys_reset_pkg::SRC_EN_RST;
			lock_next     = 1'b0;
			apb_gate_next = sys_reset_pkg::APB_GATE_RST;
			clk_ctrl_next = sys_reset_pkg::CLK_CTRL_RST;
			sw_req_next   = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			src_en_reg   <= sys_reset_pkg::SRC_EN_RST;
			status_reg   <= sys_reset_pkg::STATUS_POR_RST;
			lock_reg     <= 1'b0;
			apb_gate_reg <= sys_reset_pkg::APB_GATE_RST;
			clk_ctrl_reg <= sys_reset_pkg::CLK_CTRL_RST;
			mod_rst_reg  <= sys_reset_pkg::MOD_RST_RST;
			sw_req_reg   <= 1'b0;
			ack_reg      <= 1'b0;
			rdat_reg     <= '0;
		end
		else
		begin
			src_en_reg   <= src_en_next;
			status_reg   <= status_next;
			lock_reg     <= lock_next;
			apb_gate_reg <= apb_gate_next;
			clk_ctrl_reg <= clk_ctrl_next;
			mod_rst_reg  <= mod_rst_next;
			sw_req_reg   <= sw_req_next;
			ack_reg      <= ack_next;
			rdat_reg     <= rdat_next;
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;

	assign o_rst_pin    = 1'b0;
	assign o_rst_pin_oe = pin_drive_reg;

	assign o_core_halt  = (state_reg != sys_reset_pkg::ST_RUN);
	assign o_pc_clear   = (state_reg == sys_reset_pkg::ST_START);
	assign o_fetch_addr = sys_reset_pkg::BOOT_ADDR;

	assign o_sys_reset       = in_reset;
	assign o_mod_reset       = in_reset ? mod_rst_reg : '0;
	// RAM is never cleared; writes are blocked in the hold and sync states
	assign o_ram_write_block = in_reset;
	assign o_irq_disable     = in_reset;
	assign o_timer_disable   = in_reset;

	always_comb
	begin
		o_port.latch_one  = in_reset;
		o_port.open_drain = in_reset;
		o_port.pullup_en  = clk_ctrl_reg[sys_reset_pkg::CC_PULLUP];
		o_ahb_clk_en.flash = 1'b1;
		o_ahb_clk_en.ram   = 1'b1;
	end

	assign o_apb_clk_en  = apb_gate_reg;
	// 20 MHz default, 2.5 MHz divided selectable
	assign o_sysclk_sel  = sys_reset_pkg::sysclk_sel_t'(
		clk_ctrl_reg[sys_reset_pkg::CC_SYSCLK_LO +: 2]);
	assign o_wdt_en      = clk_ctrl_reg[sys_reset_pkg::CC_WDT_EN];
	// Low-frequency oscillator is the 16.4 kHz source
	assign o_wdt_clk_sel = sys_reset_pkg::wdt_clk_sel_t'(
		clk_ctrl_reg[sys_reset_pkg::CC_WDT_CLK]);

endmodule
`default_nettype wire

// file: sim/system_reset_state_control_props.sv
`default_nettype none
module system_reset_state_control_props (
	// Clock and reset
	input wire logic					i_sys_clk,
	input wire logic					i_rst,
	// Bus
	input wire sys_reset_pkg::wb_req_t	i_wb,
	input wire logic					o_wb_ack,
	// Pin and core
	input wire logic					o_rst_pin,
	input wire logic					o_rst_pin_oe,
	input wire logic					o_core_halt,
	input wire logic					o_pc_clear,
	input wire logic [31:0]				o_fetch_addr,
	// Fan-out
	input wire logic					o_sys_reset,
	input wire logic [4:0]				o_mod_reset,
	input wire logic					o_irq_disable,
	input wire logic					o_timer_disable,
	input wire sys_reset_pkg::port_ctrl_t	o_port,
	input wire logic [15:0]				o_apb_clk_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// Pc clear lands while still halted, so no fetch races it
	sequence s_exit;
		o_pc_clear && o_core_halt ##1 !o_pc_clear && !o_core_halt;
	endsequence
	sequence s_req;
		i_wb.cyc && i_wb.stb && !o_wb_ack;
	endsequence

	property p_halt; o_sys_reset |-> o_core_halt; endproperty
	property p_exit; $fell(o_sys_reset) |-> s_exit; endproperty
	property p_fence;
		o_sys_reset |-> o_irq_disable && o_timer_disable
			&& o_port.latch_one && o_port.open_drain;
	endproperty
	property p_gate;
		$fell(o_sys_reset) |-> o_port.pullup_en
			&& o_apb_clk_en == sys_reset_pkg::APB_GATE_RST;
	endproperty
	property p_mod; o_mod_reset != 5'h00 |-> o_sys_reset; endproperty
	property p_boot; o_fetch_addr == sys_reset_pkg::BOOT_ADDR; endproperty
	property p_pin; o_rst_pin_oe |-> !o_rst_pin && o_core_halt; endproperty
	property p_pin_exit; $fell(o_rst_pin_oe) |-> $fell(o_core_halt); endproperty
	property p_ack; s_req |=> o_wb_ack ##1 !o_wb_ack; endproperty

	a_halt: assert property (p_halt) else $error("core runs in reset");
	a_exit: assert property (p_exit) else $error("bad exit");
	a_fence: assert property (p_fence) else $error("fence off");
	a_gate: assert property (p_gate) else $error("gates off");
	a_mod: assert property (p_mod) else $error("stray module reset");
	a_boot: assert property (p_boot) else $error("boot address");
	a_pin: assert property (p_pin) else $error("pin drive");
	a_pin_exit: assert property (p_pin_exit) else $error("pin release");
	a_ack: assert property (p_ack) else $error("bus answer");
endmodule

bind system_reset_state_control system_reset_state_control_props u_props (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb(i_wb), .o_wb_ack(o_wb_ack),
	.o_rst_pin(o_rst_pin), .o_rst_pin_oe(o_rst_pin_oe),
	.o_core_halt(o_core_halt), .o_pc_clear(o_pc_clear),
	.o_fetch_addr(o_fetch_addr), .o_sys_reset(o_sys_reset),
	.o_mod_reset(o_mod_reset), .o_irq_disable(o_irq_disable),
	.o_timer_disable(o_timer_disable), .o_port(o_port),
	.o_apb_clk_en(o_apb_clk_en)
);
`default_nettype wire

// file: sim/reset_source_model.sv
`default_nettype none
module reset_source_model (
	// Clock
	input wire logic	i_sys_clk,
	// Device side of the pin
	input wire logic	i_rst_pin,
	input wire logic	i_rst_pin_oe,
	// Sources
	output logic		o_vbat_low,
	output logic		o_wdt_expired,
	output logic		o_pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pull_low;

	// Pull-up holds the wire high when nobody pulls it down
	assign o_pin_level = !pull_low
		&& ((i_rst_pin_oe === 1'h1) ? i_rst_pin : 1'h1);

	initial
	begin
		o_vbat_low = 1'h0;
		o_wdt_expired = 1'h0;
		pull_low = 1'h0;
	end

	task automatic drive(input int unsigned which, input logic lvl);
		@(posedge i_sys_clk);
		case (which)
			sys_reset_pkg::SRC_VBAT: o_vbat_low <= lvl;
			sys_reset_pkg::SRC_PIN: pull_low <= lvl;
			default: o_wdt_expired <= lvl;
		endcase
	endtask
endmodule
`default_nettype wire

// file: sim/test_system_reset_state_control.sv
`default_nettype none
module test_system_reset_state_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic							i_sys_clk, i_rst, ack, drv, oe, halt, pcc;
	logic							srst, ramb, irqd, tmrd, wdte, vbat, wdtx, pin;
	logic [31:0]					rdat, fetch, q;
	logic [4:0]						modr;
	logic [15:0]					apb;
	sys_reset_pkg::wb_req_t			wb;
	sys_reset_pkg::port_ctrl_t		port;
	sys_reset_pkg::ahb_clk_t		ahb;
	sys_reset_pkg::sysclk_sel_t		ssel;
	sys_reset_pkg::wdt_clk_sel_t	wsel;
	int unsigned					err_count, checks_done, cycles, pcs;
	logic [31:0]					dflt [8] = '{32'hF, 32'h10, 32'h0, 32'h3,
									32'h14, 32'h0, 32'h0, 32'h0};

	system_reset_state_control uut (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb(wb), .o_wb_ack(ack),
		.o_wb_dat(rdat), .i_vbat_low(vbat), .i_wdt_expired(wdtx),
		.i_rst_pin(pin), .o_rst_pin(drv), .o_rst_pin_oe(oe),
		.o_core_halt(halt), .o_pc_clear(pcc), .o_fetch_addr(fetch),
		.o_sys_reset(srst), .o_mod_reset(modr), .o_ram_write_block(ramb),
		.o_irq_disable(irqd), .o_timer_disable(tmrd), .o_port(port),
		.o_ahb_clk_en(ahb), .o_apb_clk_en(apb), .o_sysclk_sel(ssel),
		.o_wdt_en(wdte), .o_wdt_clk_sel(wsel));
	reset_source_model src (.i_sys_clk(i_sys_clk), .i_rst_pin(drv),
		.i_rst_pin_oe(oe), .o_vbat_low(vbat), .o_wdt_expired(wdtx),
		.o_pin_level(pin));

	initial
	begin
		i_sys_clk = 1'h0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	task automatic finish_test;
		$display("mismatches=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Whole run is under two hundred cycles; the 5000-cycle ceiling leaves wide margin
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (pcc === 1'h1)
			pcs++;
		if (cycles == 5000)
		begin
			err_count++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_sys_clk);
		wb <= '{1'h1, 1'h1, we, a, 4'hF, d};
		do @(posedge i_sys_clk); while (ack !== 1'h1);
		q = rdat;
		wb.cyc <= 1'h0;
		wb.stb <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'h0, a, 32'h0);
		check(q, exp);
	endtask

	task automatic run_wait;
		do @(posedge i_sys_clk); while (halt !== 1'h0);
	endtask

	initial
	begin
		i_rst = 1'h1;
		wb = '0;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		run_wait();
		check(pcs, 32'h1);
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), dflt[i]);
		check({ssel, wdte, wsel, port.pullup_en}, 5'h05);
		check(fetch, sys_reset_pkg::BOOT_ADDR);
		check({ahb, apb}, {2'h3, sys_reset_pkg::APB_GATE_RST});
		wr(sys_reset_pkg::OFS_CLK_CTRL, 32'h9);
		wr(sys_reset_pkg::OFS_APB_GATE, 32'hFFFF);
		wr(sys_reset_pkg::OFS_MOD_RST, 32'h1F);
		check({ssel, wdte, wsel, port.pullup_en, apb}, 21'h0AFFFF);
		src.drive(sys_reset_pkg::SRC_WDT, 1'h1);
		repeat (3) @(posedge i_sys_clk);
		check({halt, srst, ramb, irqd, tmrd, oe}, 6'h3E);
		check({port.latch_one, port.open_drain, modr}, 7'h7F);
		check({ahb, apb}, 18'h30003);
		wr(sys_reset_pkg::OFS_CLK_CTRL, 32'h9);
		src.drive(sys_reset_pkg::SRC_WDT, 1'h0);
		run_wait();
		rd(sys_reset_pkg::OFS_CLK_CTRL, 32'h14);
		rd(sys_reset_pkg::OFS_MOD_RST, 32'h1F);
		rd(sys_reset_pkg::OFS_STATUS, 32'h14);
		wr(sys_reset_pkg::OFS_STATUS, 32'h1F);
		wr(sys_reset_pkg::OFS_LOCK, 32'h1);
		wr(sys_reset_pkg::OFS_SRC_EN, 32'h0);
		wr(sys_reset_pkg::OFS_MOD_RST, 32'h0);
		wr(sys_reset_pkg::OFS_LOCK, 32'h0);
		rd(sys_reset_pkg::OFS_LOCK, 32'h1);
		rd(sys_reset_pkg::OFS_SRC_EN, 32'hF);
		rd(sys_reset_pkg::OFS_MOD_RST, 32'h1F);
		src.drive(sys_reset_pkg::SRC_VBAT, 1'h1);
		repeat (3) @(posedge i_sys_clk);
		check({oe, pin, halt}, 3'h5);
		src.drive(sys_reset_pkg::SRC_VBAT, 1'h0);
		run_wait();
		check(oe, 1'h0);
		rd(sys_reset_pkg::OFS_LOCK, 32'h0);
		rd(sys_reset_pkg::OFS_STATUS, 32'h1);
		wr(sys_reset_pkg::OFS_SRC_EN, 32'hB);
		src.drive(sys_reset_pkg::SRC_WDT, 1'h1);
		repeat (4) @(posedge i_sys_clk);
		check(halt, 1'h0);
		src.drive(sys_reset_pkg::SRC_WDT, 1'h0);
		wr(sys_reset_pkg::OFS_SW_RESET, 32'h1);
		repeat (2) @(posedge i_sys_clk);
		check(halt, 1'h1);
		run_wait();
		src.drive(sys_reset_pkg::SRC_PIN, 1'h1);
		repeat (3) @(posedge i_sys_clk);
		check({halt, oe}, 2'h2);
		src.drive(sys_reset_pkg::SRC_PIN, 1'h0);
		run_wait();
		rd(sys_reset_pkg::OFS_STATUS, 32'hB);
		i_rst <= 1'h1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		run_wait();
		rd(sys_reset_pkg::OFS_MOD_RST, 32'h0);
		check(pcs, 32'h6);
		finish_test();
	end
endmodule
`default_nettype wire
